/* core/lld_pkg.sv */
// Constants and types shared by the line loss detector
// What this block does
// RULE1 - Declare loss after N consecutive intervals below Q with no pulse.
// RULE2 - On declare, drive loss output high and pulse interrupt unless masked.
// RULE3 - Clear only after M intervals from a pulse above P, density at least 12.5%.
// RULE4 - On clear, drive the loss output low.
// RULE5 - Short haul declare threshold 800 mVpp, clear threshold 200 mVpp higher.
// RULE6 - Long haul declare threshold from five-bit code, clear threshold 4 dB higher.
// RULE7 - Threshold code resets to 10101, meaning -46 dB.
// RULE8 - Pin-configured long haul uses fixed -46 dB for E1, -38 dB for T1/J1.
// RULE9 - Criteria follow line standard bit (1 T1/J1, 0 E1) and criteria select.
// RULE10 - T1/J1 declare count is 175 bits, or 1544 with criteria select set.
// RULE11 - T1/J1 clear needs 128 bits, 12.5% marks, fewer than 100 zeros in a row.
// RULE12 - E1 declare count is 32 bits, or 2048 with criteria select set.
// RULE13 - E1 clear needs 32 bits, 12.5% marks, fewer than 16 zeros in a row.
// RULE14 - Short haul clear also needs received level above 1 Vpp.
// RULE15 - Software keeps T1/J1 alternate-criteria threshold within -18 to -30 dB.
// RULE16 - Software keeps E1 default-criteria threshold within -9 to -35 dB.
// RULE17 - Software keeps E1 alternate-criteria threshold within -6 to -20 dB.
// RULE18 - During loss without rx all ones, rails follow line, recovered clock continues.
// RULE19 - During loss with rx all ones, rails carry ones, clock from master clock.
// RULE20 - During loss with tx all ones, line sends ones timed by master clock.
// RULE21 - Loss detection stays active in every loopback mode.
// RULE22 - Criteria select resets to 0.
// RULE23 - Code 0 is -4 dB, 2 dB per step, codes 10110 and up are -48 dB.
// RULE24 - Counters step once per interval and restart when their condition breaks.
`default_nettype none

package lld_pkg;

  localparam int           CNT_W          = 12;
  localparam int           THR_W          = 11;
  localparam logic [11:0]  N_T1_STD       = 12'h00AF;
  localparam logic [11:0]  N_T1_ALT       = 12'h0608;
  localparam logic [11:0]  N_E1_STD       = 12'h0020;
  localparam logic [11:0]  N_E1_ALT       = 12'h0800;
  localparam logic [11:0]  M_T1           = 12'h0080;
  localparam logic [11:0]  M_E1           = 12'h0020;
  localparam logic [11:0]  ZRUN_T1        = 12'h0064;
  localparam logic [11:0]  ZRUN_E1        = 12'h0010;
  localparam int           DENSITY_SHIFT  = 3;
  localparam logic [4:0]   THR_CODE_RST   = 5'h15;
  localparam logic         CRITERIA_RST   = 1'h0;
  localparam logic [10:0]  SH_Q_MVPP      = 11'h320;
  localparam logic [10:0]  SH_HYST_MVPP   = 11'h0C8;
  localparam logic [10:0]  SH_CLR_MIN_MVPP = 11'h3E8;
  localparam logic [10:0]  LH_BASE_DB     = 11'h004;
  localparam logic [10:0]  LH_STEP_DB     = 11'h002;
  localparam logic [10:0]  LH_HYST_DB     = 11'h004;
  localparam logic [4:0]   LH_CODE_LAST   = 5'h15;
  localparam logic [10:0]  LH_FLOOR_DB    = 11'h030;
  localparam logic [10:0]  HW_E1_DB       = 11'h02E;
  localparam logic [10:0]  HW_T1_DB       = 11'h026;
  localparam int           MCLK_HZ        = 10_000_000;
  localparam int           AIS_RATE_HZ    = 2_048_000;
  localparam int           AIS_DIV        = MCLK_HZ / AIS_RATE_HZ;
  localparam int           FIFO_W         = 2;
  localparam int           FIFO_D         = 8;

  typedef enum logic [1:0] {
    ST_WATCH = 2'b00,
    ST_LOST  = 2'b01,
    ST_CLEAR = 2'b10
  } lld_state_type;

endpackage : lld_pkg

`default_nettype wire

/* core/lld_stream_if.sv */
// Valid/ready stream carrier between detector and its FIFO
`default_nettype none

interface lld_stream_if #(parameter int W = 2);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : lld_stream_if

`default_nettype wire

/* core/lld_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none

module lld_fifo #(
  parameter int W = 2,
  parameter int D = 8
) (
  input  wire logic   mclk,
  input  wire logic   rst,
  lld_stream_if.snk   in_s,
  lld_stream_if.src   out_s
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } lld_fifo_state_type;

  lld_fifo_state_type st_ff;
  lld_fifo_state_type nxt_st;
  logic               push;
  logic               pop;

  assign in_s.ready  = (st_ff.cnt != D[AW:0]);
  assign out_s.valid = (st_ff.cnt != '0);
  assign out_s.data  = st_ff.mem[st_ff.rd];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_s.data;
      nxt_st.wr            = (st_ff.wr == AW'(D - 1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == AW'(D - 1)) ? '0 : st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : lld_fifo

`default_nettype wire

/* core/lld_thresh.sv */
// Level threshold selection for declare and clear
`default_nettype none

module lld_thresh
  import lld_pkg::*;
(
  input  wire logic          long_haul_mode,
  input  wire logic          software_config,
  input  wire logic          line_standard_select,
  input  wire logic [4:0]    code,
  output logic      [10:0]   declare_level,
  output logic      [10:0]   clear_level,
  output logic               level_is_mvpp
);

  function automatic logic [10:0] code_to_db(input logic [4:0] c);
    if (c > LH_CODE_LAST) begin
      code_to_db = LH_FLOOR_DB; // RULE23
    end else begin
      code_to_db = LH_BASE_DB + LH_STEP_DB * {6'h00, c}; // RULE23
    end
  endfunction : code_to_db

  always_comb begin
    level_is_mvpp = !long_haul_mode;
    if (!long_haul_mode) begin
      declare_level = SH_Q_MVPP; // RULE5
      clear_level   = SH_Q_MVPP + SH_HYST_MVPP; // RULE5
    end else if (!software_config) begin
      declare_level = line_standard_select ? HW_T1_DB : HW_E1_DB; // RULE8
      clear_level   = declare_level - LH_HYST_DB;
    end else begin
      // Magnitudes below nominal, so 4 dB more signal is 4 less
      declare_level = code_to_db(code); // RULE6
      clear_level   = declare_level - LH_HYST_DB; // RULE6
    end
  end

endmodule : lld_thresh

`default_nettype wire

/* core/lld_line_loss_detector.sv */
// Loss-of-signal detector with all-ones substitution and receive FIFO
`default_nettype none

module lld_line_loss_detector
  import lld_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          pulse_tick,
  input  wire logic          level_below_q,
  input  wire logic          level_above_p,
  input  wire logic          level_above_1vpp,
  input  wire logic          pulse_mark,
  input  wire logic          rx_line_tip,
  input  wire logic          rx_line_ring,
  input  wire logic          rx_rec_clk,
  output logic               rx_in_ready,
  output logic               rx_positive_rail,
  output logic               rx_negative_rail,
  output logic               rx_out_valid,
  input  wire logic          rx_out_ready,
  output logic               rx_clk_out,
  input  wire logic          tx_tick,
  input  wire logic          tx_data_pos,
  input  wire logic          tx_data_neg,
  output logic               tx_line_tip,
  output logic               tx_line_ring,
  input  wire logic          long_haul_mode,
  input  wire logic          software_config,
  input  wire logic          line_standard_select,
  input  wire logic          criteria_wr,
  input  wire logic          criteria_wdata,
  input  wire logic          threshold_wr,
  input  wire logic [4:0]    threshold_wdata,
  input  wire logic          rx_all_ones_on_loss,
  input  wire logic          tx_all_ones_on_loss,
  input  wire logic [1:0]    loopback_mode,
  input  wire logic          loss_irq_mask,
  output logic               signal_loss_out,
  output logic               loss_irq,
  output logic               criteria_select,
  output logic [4:0]         loss_threshold_code,
  output logic [lld_pkg::THR_W-1:0] threshold_declare,
  output logic [lld_pkg::THR_W-1:0] threshold_clear,
  output logic               threshold_is_mvpp
);
  import lld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    lld_state_type    state;
    logic [CNT_W-1:0] below_cnt;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] mark_cnt;
    logic [CNT_W-1:0] zrun_cnt;
    logic             loss;
    logic             irq;
    logic             criteria;
    logic [4:0]       thr_code;
    logic [THR_W-1:0] thr_decl;
    logic [THR_W-1:0] thr_clr;
    logic             thr_mv;
    logic [3:0]       div_cnt;
    logic             ais_tick;
    logic             rx_pol;
    logic             tx_pol;
    logic             rx_pos;
    logic             rx_neg;
    logic             rx_valid;
    logic             rx_clk;
    logic             tx_tip;
    logic             tx_ring;
    logic             in_ready;
  } lld_core_state_type;

  lld_core_state_type st_ff;
  lld_core_state_type nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Criteria decode

  function automatic logic [CNT_W-1:0] declare_count(input logic t1, input logic alt);
    if (t1) begin
      declare_count = alt ? N_T1_ALT : N_T1_STD; // RULE10
    end else begin
      declare_count = alt ? N_E1_ALT : N_E1_STD; // RULE12
    end
  endfunction : declare_count

  function automatic logic [CNT_W-1:0] clear_window(input logic t1);
    clear_window = t1 ? M_T1 : M_E1; // RULE11 RULE13
  endfunction : clear_window

  function automatic logic [CNT_W-1:0] zero_run_limit(input logic t1);
    zero_run_limit = t1 ? ZRUN_T1 : ZRUN_E1; // RULE11 RULE13
  endfunction : zero_run_limit

  logic [CNT_W-1:0] n_need;
  logic [CNT_W-1:0] m_need;
  logic [CNT_W-1:0] z_lim;
  logic [CNT_W-1:0] mark_need;

  assign n_need    = declare_count(line_standard_select, st_ff.criteria); // RULE9
  assign m_need    = clear_window(line_standard_select); // RULE9
  assign z_lim     = zero_run_limit(line_standard_select);
  assign mark_need = m_need >> DENSITY_SHIFT;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold selection and receive FIFO

  logic [THR_W-1:0] sel_decl;
  logic [THR_W-1:0] sel_clr;
  logic             sel_mv;

  lld_thresh u_thresh (
    .long_haul_mode       (long_haul_mode),
    .software_config      (software_config),
    .line_standard_select (line_standard_select),
    .code                 (st_ff.thr_code),
    .declare_level        (sel_decl),
    .clear_level          (sel_clr),
    .level_is_mvpp        (sel_mv)
  );

  lld_stream_if #(.W(FIFO_W)) fifo_in ();
  lld_stream_if #(.W(FIFO_W)) fifo_out ();

  lld_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .mclk  (mclk),
    .rst   (rst),
    .in_s  (fifo_in),
    .out_s (fifo_out)
  );

  logic ais_rx;
  logic ais_tx;
  logic out_free;

  // Front end presents each sample for one tick only; it is dropped if the FIFO is full
  assign fifo_in.data  = {rx_line_tip, rx_line_ring};
  assign fifo_in.valid = pulse_tick;
  assign ais_rx        = st_ff.loss && rx_all_ones_on_loss; // RULE19
  assign ais_tx        = st_ff.loss && tx_all_ones_on_loss; // RULE20
  assign out_free      = !st_ff.rx_valid || rx_out_ready;
  // Stale line data is flushed while ones are substituted
  assign fifo_out.ready = ais_rx || out_free;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic             clr_ok;
  logic [CNT_W-1:0] win_n;
  logic [CNT_W-1:0] mark_n;
  logic [CNT_W-1:0] zrun_n;

  always_comb begin
    nxt_st   = st_ff;
    nxt_st.irq = 1'b0;
    clr_ok   = level_above_p && (long_haul_mode || level_above_1vpp); // RULE3 RULE14
    win_n    = st_ff.win_cnt + 1'b1;
    mark_n   = st_ff.mark_cnt + CNT_W'(pulse_mark);
    zrun_n   = pulse_mark ? '0 : st_ff.zrun_cnt + 1'b1;

    if (criteria_wr) begin
      nxt_st.criteria = criteria_wdata;
    end
    if (threshold_wr) begin
      nxt_st.thr_code = threshold_wdata;
    end
    nxt_st.thr_decl = sel_decl;
    nxt_st.thr_clr  = sel_clr;
    nxt_st.thr_mv   = sel_mv;

    // Loopback selection never gates the detector
    if (pulse_tick) begin // RULE21
      unique case (st_ff.state)
        ST_WATCH: begin
          if (level_below_q && !pulse_mark) begin // RULE1
            nxt_st.below_cnt = st_ff.below_cnt + 1'b1;
            if (st_ff.below_cnt + 1'b1 >= n_need) begin // RULE1
              nxt_st.loss      = 1'b1; // RULE2
              nxt_st.irq       = !loss_irq_mask; // RULE2
              nxt_st.state     = ST_LOST;
              nxt_st.below_cnt = '0;
            end
          end else begin
            nxt_st.below_cnt = '0; // RULE24
          end
        end
        ST_LOST: begin
          // Window opens only on a received pulse
          if (pulse_mark && clr_ok) begin // RULE3
            nxt_st.state    = ST_CLEAR;
            nxt_st.win_cnt  = 12'h0001;
            nxt_st.mark_cnt = 12'h0001;
            nxt_st.zrun_cnt = '0;
          end
        end
        ST_CLEAR: begin
          nxt_st.win_cnt  = win_n;
          nxt_st.mark_cnt = mark_n;
          nxt_st.zrun_cnt = zrun_n;
          if (!clr_ok || zrun_n >= z_lim) begin // RULE24 RULE11 RULE13
            nxt_st.state = ST_LOST;
          end else if (win_n >= m_need) begin
            if (mark_n >= mark_need) begin // RULE3
              nxt_st.loss  = 1'b0; // RULE4
              nxt_st.state = ST_WATCH;
            end else begin
              nxt_st.state = ST_LOST;
            end
          end
        end
        default: begin
          nxt_st.state = ST_WATCH;
        end
      endcase
    end

    // Master clock divider for all-ones timing
    nxt_st.ais_tick = 1'b0;
    if (st_ff.div_cnt == 4'(AIS_DIV - 1)) begin
      nxt_st.div_cnt  = '0;
      nxt_st.ais_tick = 1'b1;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
    end

    // Receive side
    if (st_ff.rx_valid && rx_out_ready) begin
      nxt_st.rx_valid = 1'b0;
    end
    if (ais_rx) begin
      // Divided master clock stands in for the recovered clock
      nxt_st.rx_clk = st_ff.div_cnt < 4'(AIS_DIV / 2); // RULE19
      if (st_ff.ais_tick && out_free) begin
        nxt_st.rx_pol   = !st_ff.rx_pol;
        nxt_st.rx_pos   = !st_ff.rx_pol; // RULE19
        nxt_st.rx_neg   = st_ff.rx_pol; // RULE19
        nxt_st.rx_valid = 1'b1;
      end
    end else begin
      nxt_st.rx_clk = rx_rec_clk; // RULE18
      if (fifo_out.valid && out_free) begin
        nxt_st.rx_pos   = fifo_out.data[1]; // RULE18
        nxt_st.rx_neg   = fifo_out.data[0]; // RULE18
        nxt_st.rx_valid = 1'b1;
      end
    end
    nxt_st.in_ready = fifo_in.ready;

    // Transmit side
    if (ais_tx) begin
      if (st_ff.ais_tick) begin
        nxt_st.tx_pol  = !st_ff.tx_pol;
        nxt_st.tx_tip  = !st_ff.tx_pol; // RULE20
        nxt_st.tx_ring = st_ff.tx_pol; // RULE20
      end
    end else if (tx_tick) begin
      nxt_st.tx_tip  = tx_data_pos;
      nxt_st.tx_ring = tx_data_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff          <= '0;
      st_ff.state    <= ST_WATCH;
      st_ff.criteria <= CRITERIA_RST; // RULE22
      st_ff.thr_code <= THR_CODE_RST; // RULE7
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign signal_loss_out     = st_ff.loss; // RULE2 RULE4
  assign loss_irq            = st_ff.irq;
  assign criteria_select     = st_ff.criteria;
  assign loss_threshold_code = st_ff.thr_code;
  assign threshold_declare   = st_ff.thr_decl;
  assign threshold_clear     = st_ff.thr_clr;
  assign threshold_is_mvpp   = st_ff.thr_mv;
  assign rx_positive_rail    = st_ff.rx_pos;
  assign rx_negative_rail    = st_ff.rx_neg;
  assign rx_out_valid        = st_ff.rx_valid;
  assign rx_clk_out          = st_ff.rx_clk;
  assign rx_in_ready         = st_ff.in_ready;
  assign tx_line_tip         = st_ff.tx_tip;
  assign tx_line_ring        = st_ff.tx_ring;

  // Loopback mode is informational to the detector only
  logic unused_loop;
  assign unused_loop = ^loopback_mode;

endmodule : lld_line_loss_detector

`default_nettype wire

/* testbench/lld_checker_sva.sv */
// Port checker for the line loss detector
`default_nettype none

module lld_checker
  import lld_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             pulse_tick,
  input wire logic             level_below_q,
  input wire logic             level_above_p,
  input wire logic             pulse_mark,
  input wire logic             rx_rec_clk,
  input wire logic             rx_clk_out,
  input wire logic             tx_line_tip,
  input wire logic             long_haul_mode,
  input wire logic             rx_all_ones_on_loss,
  input wire logic             tx_all_ones_on_loss,
  input wire logic             loss_irq_mask,
  input wire logic             signal_loss_out,
  input wire logic             loss_irq,
  input wire logic [THR_W-1:0] threshold_declare,
  input wire logic [THR_W-1:0] threshold_clear,
  input wire logic             threshold_is_mvpp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [11:0] below_run_ff;
  logic [3:0]  tip_gap_ff, rclk_gap_ff;
  //////////////////////////////////////////////////
  // Shortest legal run is the E1 default count, so any rise below it is early
  always_ff @(posedge mclk) begin
    if (rst || (pulse_tick && !(level_below_q && !pulse_mark)))
      below_run_ff <= 12'h0000;
    else if (pulse_tick && below_run_ff != 12'h0FFF)
      below_run_ff <= below_run_ff + 12'h0001;
  end
  always_ff @(posedge mclk) begin
    if (rst || !(signal_loss_out && tx_all_ones_on_loss) || tx_line_tip)
      tip_gap_ff <= 4'h0;
    else
      tip_gap_ff <= tip_gap_ff + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst || !(signal_loss_out && rx_all_ones_on_loss) || $changed(rx_clk_out))
      rclk_gap_ff <= 4'h0;
    else
      rclk_gap_ff <= rclk_gap_ff + 4'h1;
  end
  //////////////////////////////////////////////////
  sequence s_loss_rise;
    !signal_loss_out ##1 signal_loss_out;
  endsequence
  sequence s_lh_settled;
    $past(long_haul_mode, 2) && $past(long_haul_mode) && !$past(rst, 2);
  endsequence
  sequence s_sh_settled;
    !$past(long_haul_mode, 2) && !$past(long_haul_mode) && !$past(rst, 2);
  endsequence
  property p_declare_cause;
    $rose(signal_loss_out) |-> $past(pulse_tick && level_below_q && !pulse_mark);
  endproperty
  property p_declare_count;
    $rose(signal_loss_out) |-> below_run_ff >= N_E1_STD;
  endproperty
  property p_clear_cause;
    $fell(signal_loss_out) |-> $past(pulse_tick && level_above_p);
  endproperty
  property p_irq_on_declare;
    s_loss_rise |-> loss_irq == !$past(loss_irq_mask);
  endproperty
  property p_irq_cause;
    loss_irq |-> $rose(signal_loss_out) ##1 !loss_irq;
  endproperty
  property p_thr_short;
    s_sh_settled |-> threshold_is_mvpp && threshold_declare == SH_Q_MVPP
      && threshold_clear == SH_CLR_MIN_MVPP;
  endproperty
  property p_thr_hyst;
    s_lh_settled |-> !threshold_is_mvpp && threshold_clear == threshold_declare - LH_HYST_DB;
  endproperty
  property p_rx_clk_follow;
    !$past(rst) && !rx_all_ones_on_loss && $past(!rx_all_ones_on_loss)
      |-> rx_clk_out == $past(rx_rec_clk);
  endproperty
  property p_tx_ais;
    tip_gap_ff != 4'hC;
  endproperty
  property p_rx_ais;
    rclk_gap_ff != 4'hC;
  endproperty
  a_declare_cause: assert property (p_declare_cause)
    else $error("loss rose without a silent interval");
  a_declare_count: assert property (p_declare_count)
    else $error("loss rose after too short a run");
  a_clear_cause: assert property (p_clear_cause)
    else $error("loss fell without a good interval");
  a_irq_on_declare: assert property (p_irq_on_declare)
    else $error("interrupt wrong at declare");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt outside declare");
  a_thr_short: assert property (p_thr_short)
    else $error("short haul thresholds wrong");
  a_thr_hyst: assert property (p_thr_hyst)
    else $error("long haul hysteresis wrong");
  a_rx_clk_follow: assert property (p_rx_clk_follow)
    else $error("receive clock not following");
  a_tx_ais: assert property (p_tx_ais)
    else $error("no transmit alarm marks");
  a_rx_ais: assert property (p_rx_ais)
    else $error("receive clock not substituted");
endmodule : lld_checker

bind lld_line_loss_detector lld_checker chk_u (.mclk, .rst, .pulse_tick, .level_below_q,
  .level_above_p, .pulse_mark, .rx_rec_clk, .rx_clk_out, .tx_line_tip, .long_haul_mode,
  .rx_all_ones_on_loss, .tx_all_ones_on_loss, .loss_irq_mask, .signal_loss_out, .loss_irq,
  .threshold_declare, .threshold_clear, .threshold_is_mvpp);

`default_nettype wire

/* testbench/lld_front_end_model.sv */
// Behavioural analogue front end giving one report per pulse interval
`default_nettype none

module lld_front_end_model (
  output logic pulse_tick,
  output logic level_below_q,
  output logic level_above_p,
  output logic level_above_1vpp,
  output logic pulse_mark,
  output logic rx_line_tip,
  output logic rx_line_ring,
  output logic rx_rec_clk,
  input  wire logic mclk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase = 1'b0;
  initial begin
    {pulse_tick, level_below_q, level_above_p, level_above_1vpp} = 4'h0;
    {pulse_mark, rx_line_tip, rx_line_ring, rx_rec_clk} = 4'h0;
  end
  //////////////////////////////////////////////////
  // Silent line when mark_per is 0, else a mark every mark_per intervals
  task automatic send(input int n, input int mark_per, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) begin
        @(negedge mclk);
        pulse_tick = 1'b0;
        // Qualifiers scrambled off the tick, only meaningful with it
        level_below_q = ~level_below_q;
        pulse_mark = ~pulse_mark;
      end
      @(negedge mclk);
      pulse_tick = 1'b1;
      level_below_q = (mark_per == 0);
      level_above_p = (mark_per != 0);
      level_above_1vpp = (mark_per != 0);
      pulse_mark = (mark_per != 0) && (i % mark_per == 0);
      rx_line_tip = pulse_mark && !phase;
      rx_line_ring = pulse_mark && phase;
      phase = phase ^ pulse_mark;
      rx_rec_clk = ~rx_rec_clk;
    end
    @(negedge mclk);
    pulse_tick = 1'b0;
  endtask : send
endmodule : lld_front_end_model

`default_nettype wire

/* testbench/line_loss_detector_tb.sv */
// Self-checking bench for the line loss detector
`default_nettype none

module line_loss_detector_tb;
  import lld_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, rx_out_ready = 1'b1, tx_tick = 1'b0;
  logic tx_data_pos = 1'b0, tx_data_neg = 1'b0, long_haul_mode = 1'b1;
  logic software_config = 1'b1, line_standard_select = 1'b0;
  logic criteria_wr = 1'b0, criteria_wdata = 1'b0, threshold_wr = 1'b0;
  logic [4:0] threshold_wdata = 5'h00;
  logic rx_all_ones_on_loss = 1'b0, tx_all_ones_on_loss = 1'b0, loss_irq_mask = 1'b0;
  logic [1:0] loopback_mode = 2'h0;
  logic pulse_tick, level_below_q, level_above_p, level_above_1vpp, pulse_mark;
  logic rx_line_tip, rx_line_ring, rx_rec_clk, rx_in_ready, rx_positive_rail;
  logic rx_negative_rail, rx_out_valid, rx_clk_out, tx_line_tip, tx_line_ring;
  logic signal_loss_out, loss_irq, criteria_select, threshold_is_mvpp;
  logic [4:0] loss_threshold_code;
  logic [THR_W-1:0] threshold_declare, threshold_clear;
  int failures = 0, check_count = 0;

  always #50 mclk = ~mclk;

  lld_front_end_model fe_u (.pulse_tick, .level_below_q, .level_above_p, .level_above_1vpp,
    .pulse_mark, .rx_line_tip, .rx_line_ring, .rx_rec_clk, .mclk);

  lld_line_loss_detector dut_u (.mclk, .rst, .pulse_tick, .level_below_q, .level_above_p,
    .level_above_1vpp, .pulse_mark, .rx_line_tip, .rx_line_ring, .rx_rec_clk, .rx_in_ready,
    .rx_positive_rail, .rx_negative_rail, .rx_out_valid, .rx_out_ready, .rx_clk_out,
    .tx_tick, .tx_data_pos, .tx_data_neg, .tx_line_tip, .tx_line_ring, .long_haul_mode,
    .software_config, .line_standard_select, .criteria_wr, .criteria_wdata, .threshold_wr,
    .threshold_wdata, .rx_all_ones_on_loss, .tx_all_ones_on_loss, .loopback_mode,
    .loss_irq_mask, .signal_loss_out, .loss_irq, .criteria_select, .loss_threshold_code,
    .threshold_declare, .threshold_clear, .threshold_is_mvpp);
  //////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic code, input logic [4:0] v);
    @(negedge mclk);
    threshold_wdata = v;
    criteria_wdata = v[0];
    {threshold_wr, criteria_wr} = {code, !code};
    @(negedge mclk);
    {threshold_wr, criteria_wr} = 2'h0;
  endtask : wr

  task automatic thr(input logic [10:0] d, input logic [10:0] c);
    repeat (3) @(negedge mclk);
    chk(threshold_declare, d);
    chk(threshold_clear, c);
  endtask : thr

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////
  initial begin
    static logic [11:0] n_tab [4] = '{N_T1_STD, N_T1_ALT, N_E1_STD, N_E1_ALT};
    static logic [4:0]  cd_tab [4] = '{5'h15, 5'h0A, 5'h08, 5'h05};
    static logic [4:0]  c_tab [4] = '{5'h00, 5'h10, 5'h16, 5'h1F};
    static logic [10:0] d_tab [4] = '{11'h004, 11'h024, 11'h030, 11'h030};
    int m, cnt;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk(loss_threshold_code, 5'h15);
    chk(criteria_select, 1'b0);
    chk({signal_loss_out, loss_irq}, 2'h0);
    thr(11'h02E, 11'h02A);
    for (int k = 0; k < 4; k++) begin
      wr(1'b1, c_tab[k]);
      thr(d_tab[k], d_tab[k] - 11'h004);
    end
    long_haul_mode = 1'b0;
    thr(11'h320, 11'h3E8);
    chk(threshold_is_mvpp, 1'b1);
    {long_haul_mode, software_config} = 2'b10;
    thr(11'h02E, 11'h02A);
    line_standard_select = 1'b1;
    thr(11'h026, 11'h022);
    software_config = 1'b1;
    $display("test thresholds done");
    for (int k = 0; k < 4; k++) begin
      line_standard_select = (k < 2);
      loopback_mode = 2'(k);
      loss_irq_mask = (k == 1);
      wr(1'b0, 5'(k % 2));
      chk(criteria_select, k % 2);
      wr(1'b1, cd_tab[k]);
      chk(loss_threshold_code, cd_tab[k]);
      m = (k < 2) ? M_T1 : M_E1;
      fe_u.send(n_tab[k] - 1, 0, k % 2);
      fe_u.send(1, 1, 0);
      chk(signal_loss_out, 1'b0);
      fe_u.send(n_tab[k] - 1, 0, k % 2);
      chk(signal_loss_out, 1'b0);
      fe_u.send(1, 0, 0);
      chk(signal_loss_out, 1'b1);
      chk(loss_irq, k != 1);
      {rx_all_ones_on_loss, tx_all_ones_on_loss} = 2'h3;
      cnt = 0;
      repeat (20) begin
        @(negedge mclk);
        cnt += rx_out_valid && (rx_positive_rail ^ rx_negative_rail);
      end
      chk(cnt, 20 / AIS_DIV);
      {rx_all_ones_on_loss, tx_all_ones_on_loss} = 2'h0;
      fe_u.send(m, 16, 0);
      chk(signal_loss_out, 1'b1);
      fe_u.send(m - 1, 8, 1);
      chk(signal_loss_out, 1'b1);
      fe_u.send(1, 8, 0);
      chk(signal_loss_out, 1'b0);
      $display("test criteria %0d done", k);
    end
    rx_out_ready = 1'b0;
    fe_u.send(10, 1, 1);
    chk(rx_in_ready, 1'b0);
    rx_out_ready = 1'b1;
    cnt = 0;
    repeat (20) begin
      if (rx_out_valid === 1'b1) begin
        cnt++;
        chk(rx_positive_rail ^ rx_negative_rail, 1'b1);
      end
      @(negedge mclk);
    end
    chk(cnt, FIFO_D + 1);
    $display("test buffer done");
    for (int k = 0; k < 2; k++) begin
      tx_data_pos = k[0];
      tx_data_neg = !k[0];
      tx_tick = 1'b1;
      @(negedge mclk);
      tx_tick = 1'b0;
      chk({tx_line_tip, tx_line_ring}, {k[0], !k[0]});
    end
    $display("test transmit done");
    wrap_up;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule : line_loss_detector_tb

`default_nettype wire
